// ---- rsq_board_model.sv ----
// Board side: clocks, power-on reset, straps, lock and wired reset lines
`timescale 1ns/1ps
module rsq_board_model (
  input wire logic clk_sys, // System clock
  input wire logic por_cmd, // 1 holds power-on reset
  input wire logic ext_hard, // 1 pulls hard line
  input wire logic ext_soft, // 1 pulls soft line
  input wire logic slow_lock, // 1 locks PLL late
  input wire logic [4:0] strap_cfg, // Host, divide, source
  input wire logic hard_oe_n, // Device hard enable
  input wire logic soft_oe_n, // Device soft enable
  input wire logic strap_oe_n, // Device strap enable
  output logic por_n, // Power-on reset pin
  output logic hard_n, // Hard line level
  output logic soft_n, // Soft line level
  output logic pclk, // Primary clock
  output logic bclk, // Bus clock
  output logic [4:0] straps, // Strap pins
  output logic pll_lock, // PLL lock
  output logic dll_lock // DLL lock
);
  int cnt = 0;
  initial begin
    pclk = 1'b0;
    bclk = 1'b0;
  end
  always #20 pclk = ~pclk;
  always #30 bclk = ~bclk;
  assign por_n = !por_cmd;
  // Pull-up lines, low if anyone pulls
  assign hard_n = hard_oe_n && !ext_hard;
  assign soft_n = soft_oe_n && !ext_soft;
  // Clash with the device's drivers shows as the inverse
  assign straps = strap_oe_n ? strap_cfg : ~strap_cfg;
  always @(posedge clk_sys) cnt <= por_cmd ? 0 : cnt + 1;
  assign pll_lock = cnt >= (slow_lock ? 80 : 20);
  // Slow case overruns the bench's shortened DLL watchdog on purpose
  assign dll_lock = cnt >= (slow_lock ? 200 : 50);
endmodule

// ---- rsq_defines.svh ----
// Timing counts, counter widths and sync input index layout of the reset sequencer
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

`define RSQ_CLK_PERIOD_PS 5000
`define RSQ_IN_ASSERT_MIN 32
`define RSQ_OUT_ASSERT_MIN 512
`define RSQ_HARD_TO_SOFT_MIN 16
`define RSQ_STRAP_TURNON_MIN 1
`define RSQ_PLL_LOCK_MAX_US 100
`define RSQ_PLL_LOCK_CYCLES ((`RSQ_PLL_LOCK_MAX_US * 1000000) / `RSQ_CLK_PERIOD_PS)
`define RSQ_DLL_LOCK_MIN 7680
`define RSQ_DLL_LOCK_MAX 122880
`define RSQ_SYNC_COUNT_W 10
`define RSQ_IN_COUNT_W 6
`define RSQ_PLL_COUNT_W 16
`define RSQ_DLL_COUNT_W 17
`define RSQ_SRC_W 3
`define RSQ_NUM_SYNC 7
`define RSQ_IX_POR 0
`define RSQ_IX_HARD 1
`define RSQ_IX_SOFT 2
`define RSQ_IX_HOSTCLK 3
`define RSQ_IX_BUSCLK 4
`define RSQ_IX_PLL 5
`define RSQ_IX_DLL 6

`endif

// ---- rsq_pkg.sv ----
// Types of the reset sequencer
package rsq_pkg;
  typedef enum logic [2:0] {
    ST_POR,
    ST_PLL,
    ST_DLL,
    ST_HARD,
    ST_SPACE,
    ST_SOFT,
    ST_RUN
  } rsq_state_type;
endpackage

// ---- rsq_reset_init_sequencer.sv ----
// Reset initialisation sequencer: reset lines, straps, PLL and DLL lock
//
// Datasheet rules this block follows or relies on
// [R1] External reset request needs 32 sync periods
// [R2] Host mode power-on reset held 32 primary
// [R3] Agent mode power-on reset held 32 sync
// [R4] Drive reset lines at least 512 sync
// [R5] Soft release 16 sync after hard release
// [R6] Host mode straps valid 4 primary before
// [R7] Agent mode straps valid 4 sync before
// [R8] Stop driving straps within 4 ns
// [R9] Resume strap drive 1 sync after hard
// [R10] DLL lock within 7680 to 122880 cycles
// [R11] Hold internal logic until PLL reports lock
// [R12] Primary clock from host or bus input
// [R13] Host mode sync period from divide strap
// [R14] Reset lines only pulled low, else released
`timescale 1ns/1ps
`include "rsq_defines.svh"
module rsq_reset_init_sequencer #(
  parameter int PLL_LOCK_CYCLES = `RSQ_PLL_LOCK_CYCLES,
  parameter int DLL_LOCK_MAX_CYCLES = `RSQ_DLL_LOCK_MAX
) (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic power_on_reset_in_n, // Power-on reset pin, active low
  input wire logic hard_reset_line_in_n, // Hard reset wire level
  output logic hard_reset_line_out, // Hard reset drive value, always 0
  output logic hard_reset_line_oe_n, // Low while pulling hard reset low
  input wire logic soft_reset_line_in_n, // Soft reset wire level
  output logic soft_reset_line_out, // Soft reset drive value, always 0
  output logic soft_reset_line_oe_n, // Low while pulling soft reset low
  input wire logic primary_clock_in, // Host clock input pin
  input wire logic bus_clock_in, // Bus clock input pin
  input wire logic host_mode_strap, // 1 host mode, 0 agent mode
  input wire logic input_clock_divide_strap, // 1 halves primary for sync clock in host mode
  input wire logic [`RSQ_SRC_W-1:0] reset_source_strap, // Reset source straps
  input wire logic pll_lock_in, // PLL lock indication
  input wire logic dll_lock_in, // DLL lock indication
  output logic [`RSQ_SRC_W-1:0] cfg_reset_source_q, // Latched reset source
  output logic cfg_clock_divide_q, // Latched divide strap
  output logic cfg_host_mode_q, // Latched host mode
  output logic strap_out_oe_n, // Low while device drives strap pins
  output logic core_reset_n_q, // Internal logic reset, active low
  output logic sync_tick_q, // One pulse per sync clock period
  output logic pll_timeout_q, // PLL lock overdue, sticky
  output logic dll_timeout_q // DLL lock overdue, sticky
);
  logic [`RSQ_NUM_SYNC-1:0] pins;
  logic [`RSQ_NUM_SYNC-1:0] lvl;
  logic [`RSQ_NUM_SYNC-1:0] rise;
  rsq_pkg::rsq_state_type state_q;
  rsq_pkg::rsq_state_type state_d;
  logic prim_tick;
  logic half_q;
  logic sync_tick_d;
  logic [`RSQ_SYNC_COUNT_W-1:0] tick_cnt_q;
  logic [`RSQ_IN_COUNT_W-1:0] hard_in_cnt_q;
  logic [`RSQ_IN_COUNT_W-1:0] soft_in_cnt_q;
  logic [`RSQ_PLL_COUNT_W-1:0] pll_cnt_q;
  logic [`RSQ_DLL_COUNT_W-1:0] dll_cnt_q;
  logic hard_drive_q;
  logic soft_drive_q;
  logic soft_only_q;
  logic hard_req;
  logic soft_req;
  logic por_active;

  assign pins = {dll_lock_in, pll_lock_in, bus_clock_in, primary_clock_in,
                 soft_reset_line_in_n, hard_reset_line_in_n, power_on_reset_in_n};

  rsq_sync_edge #(.W(`RSQ_NUM_SYNC)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .pin_in(pins),
    .level_q(lvl),
    .rise(rise)
  );

  assign por_active = !lvl[`RSQ_IX_POR];

  // Primary clock source depends on bus role
  assign prim_tick = cfg_host_mode_q ? rise[`RSQ_IX_HOSTCLK] : rise[`RSQ_IX_BUSCLK]; // [R12]

  // Divide strap halves the primary rate in host mode
  always_comb begin
    if (cfg_host_mode_q && cfg_clock_divide_q) begin
      sync_tick_d = prim_tick && half_q; // [R13]
    end else begin
      sync_tick_d = prim_tick;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
      sync_tick_q <= 1'b0;
    end else if (ce) begin
      if (prim_tick) begin
        half_q <= !half_q;
      end
      sync_tick_q <= sync_tick_d;
    end
  end

  // Straps follow the pins while power-on reset is held, freeze at release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reset_source_q <= 3'h0;
      cfg_clock_divide_q <= 1'b0;
      cfg_host_mode_q <= 1'b1;
    end else if (ce && por_active) begin
      cfg_reset_source_q <= reset_source_strap; // [R6] [R7]
      cfg_clock_divide_q <= input_clock_divide_strap;
      cfg_host_mode_q <= host_mode_strap;
    end
  end

  // Filter external requests; only lines not driven by us count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hard_in_cnt_q <= 6'h00;
      soft_in_cnt_q <= 6'h00;
    end else if (ce) begin
      if (lvl[`RSQ_IX_HARD] || hard_drive_q) begin
        hard_in_cnt_q <= 6'h00;
      end else if (sync_tick_q && hard_in_cnt_q != 6'(`RSQ_IN_ASSERT_MIN)) begin
        hard_in_cnt_q <= hard_in_cnt_q + 6'h01;
      end
      if (lvl[`RSQ_IX_SOFT] || soft_drive_q) begin
        soft_in_cnt_q <= 6'h00;
      end else if (sync_tick_q && soft_in_cnt_q != 6'(`RSQ_IN_ASSERT_MIN)) begin
        soft_in_cnt_q <= soft_in_cnt_q + 6'h01;
      end
    end
  end

  assign hard_req = hard_in_cnt_q == 6'(`RSQ_IN_ASSERT_MIN); // [R1]
  assign soft_req = soft_in_cnt_q == 6'(`RSQ_IN_ASSERT_MIN); // [R1]

  always_comb begin
    state_d = state_q;
    case (state_q)
      rsq_pkg::ST_POR: begin
        if (!por_active) begin
          state_d = rsq_pkg::ST_PLL; // [R2] [R3]
        end
      end
      rsq_pkg::ST_PLL: begin
        if (lvl[`RSQ_IX_PLL]) begin
          state_d = rsq_pkg::ST_DLL; // [R11]
        end
      end
      rsq_pkg::ST_DLL: begin
        if (lvl[`RSQ_IX_DLL]) begin
          state_d = rsq_pkg::ST_HARD; // [R10]
        end
      end
      rsq_pkg::ST_HARD: begin
        if (sync_tick_q && tick_cnt_q == 10'(`RSQ_OUT_ASSERT_MIN - 1)) begin
          state_d = soft_only_q ? rsq_pkg::ST_RUN : rsq_pkg::ST_SPACE; // [R4]
        end
      end
      rsq_pkg::ST_SPACE: begin
        if (sync_tick_q && tick_cnt_q == 10'(`RSQ_HARD_TO_SOFT_MIN - 1)) begin
          state_d = rsq_pkg::ST_SOFT; // [R5]
        end
      end
      rsq_pkg::ST_SOFT: begin
        state_d = rsq_pkg::ST_RUN;
      end
      rsq_pkg::ST_RUN: begin
        if (hard_req) begin
          state_d = rsq_pkg::ST_PLL;
        end else if (soft_req) begin
          state_d = rsq_pkg::ST_HARD;
        end
      end
      default: begin
        state_d = rsq_pkg::ST_POR;
      end
    endcase
    if (por_active) begin
      state_d = rsq_pkg::ST_POR;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= rsq_pkg::ST_POR;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Sync period counter restarts on each state change
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 10'h000;
    end else if (ce) begin
      if (state_d != state_q) begin
        tick_cnt_q <= 10'h000;
      end else if (sync_tick_q && tick_cnt_q != 10'h3FF) begin
        tick_cnt_q <= tick_cnt_q + 10'h001;
      end
    end
  end

  // Soft-only request asserts soft line alone for the full hold time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_only_q <= 1'b0;
    end else if (ce) begin
      if (state_q == rsq_pkg::ST_RUN) begin
        soft_only_q <= soft_req && !hard_req;
      end else if (state_q != rsq_pkg::ST_HARD) begin
        soft_only_q <= 1'b0;
      end
    end
  end

  // Line drive; hard and soft both held low from power-on through lock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hard_drive_q <= 1'b1;
      soft_drive_q <= 1'b1;
      core_reset_n_q <= 1'b0;
    end else if (ce) begin
      hard_drive_q <= !(state_d == rsq_pkg::ST_RUN || state_d == rsq_pkg::ST_SPACE
                       || state_d == rsq_pkg::ST_SOFT || soft_only_q_next(state_d));
      soft_drive_q <= state_d != rsq_pkg::ST_RUN && state_d != rsq_pkg::ST_SOFT; // [R5]
      core_reset_n_q <= state_d == rsq_pkg::ST_RUN
                        || state_d == rsq_pkg::ST_SPACE || state_d == rsq_pkg::ST_SOFT; // [R11]
    end
  end

  function automatic logic soft_only_q_next(input rsq_pkg::rsq_state_type s);
    soft_only_q_next = (s == rsq_pkg::ST_HARD) && (soft_only_q
                       || (state_q == rsq_pkg::ST_RUN && !hard_req));
  endfunction

  // Open-drain: value pinned low, only the enable moves
  assign hard_reset_line_out = 1'b0; // [R14]
  assign soft_reset_line_out = 1'b0; // [R14]
  assign hard_reset_line_oe_n = !hard_drive_q; // [R14]
  assign soft_reset_line_oe_n = !soft_drive_q; // [R14]

  // Strap drive off in the same edge hard reset asserts; back one sync tick later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_out_oe_n <= 1'b1;
    end else if (ce) begin
      if (hard_drive_q || state_d == rsq_pkg::ST_PLL || state_d == rsq_pkg::ST_POR) begin
        strap_out_oe_n <= 1'b1; // [R8]
      end else if (sync_tick_q && tick_cnt_q >= 10'(`RSQ_STRAP_TURNON_MIN - 1)) begin
        strap_out_oe_n <= 1'b0; // [R9]
      end
    end
  end

  // Lock watchdogs; overdue lock is flagged, sequence still waits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pll_cnt_q <= 16'h0000;
      dll_cnt_q <= 17'h00000;
      pll_timeout_q <= 1'b0;
      dll_timeout_q <= 1'b0;
    end else if (ce) begin
      if (state_q != rsq_pkg::ST_PLL) begin
        pll_cnt_q <= 16'h0000;
      end else if (pll_cnt_q != 16'(PLL_LOCK_CYCLES)) begin
        pll_cnt_q <= pll_cnt_q + 16'h0001;
      end else begin
        pll_timeout_q <= 1'b1; // [R11]
      end
      if (state_q != rsq_pkg::ST_DLL) begin
        dll_cnt_q <= 17'h00000;
      end else if (dll_cnt_q != 17'(DLL_LOCK_MAX_CYCLES)) begin
        dll_cnt_q <= dll_cnt_q + 17'h00001;
      end else begin
        dll_timeout_q <= 1'b1; // [R10]
      end
      if (por_active) begin
        pll_timeout_q <= 1'b0;
        dll_timeout_q <= 1'b0;
      end
    end
  end
endmodule

// ---- rsq_reset_init_sequencer_bench.sv ----
// Self-checking bench of the reset sequencer
`timescale 1ns/1ps
module rsq_reset_init_sequencer_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, por_cmd = 1'b1, ext_hard = 1'b0, ext_soft = 1'b0;
  logic slow_lock = 1'b0, ce = 1'b1;
  logic [4:0] strap_cfg = 5'h00;
  logic por_n, hard_n, soft_n, pclk, bclk, pll, dll, hoe, soe, stoe, hout, sout;
  logic cfg_div, cfg_host, core_n, tick, pto, dto;
  logic [4:0] straps;
  logic [2:0] cfg_src;
  int errors = 0, cmp_count = 0, cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  rsq_board_model u_board (.clk_sys(clk_sys), .por_cmd(por_cmd), .ext_hard(ext_hard),
    .ext_soft(ext_soft), .slow_lock(slow_lock), .strap_cfg(strap_cfg), .hard_oe_n(hoe),
    .soft_oe_n(soe), .strap_oe_n(stoe), .por_n(por_n), .hard_n(hard_n), .soft_n(soft_n),
    .pclk(pclk), .bclk(bclk), .straps(straps), .pll_lock(pll), .dll_lock(dll));
  rsq_reset_init_sequencer #(.PLL_LOCK_CYCLES(50), .DLL_LOCK_MAX_CYCLES(100)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .power_on_reset_in_n(por_n),
    .hard_reset_line_in_n(hard_n), .hard_reset_line_out(hout), .hard_reset_line_oe_n(hoe),
    .soft_reset_line_in_n(soft_n), .soft_reset_line_out(sout), .soft_reset_line_oe_n(soe),
    .primary_clock_in(pclk), .bus_clock_in(bclk), .host_mode_strap(straps[4]),
    .input_clock_divide_strap(straps[3]), .reset_source_strap(straps[2:0]),
    .pll_lock_in(pll), .dll_lock_in(dll), .cfg_reset_source_q(cfg_src),
    .cfg_clock_divide_q(cfg_div), .cfg_host_mode_q(cfg_host), .strap_out_oe_n(stoe),
    .core_reset_n_q(core_n), .sync_tick_q(tick), .pll_timeout_q(pto), .dll_timeout_q(dto));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      stop_test();
    end
  end
  task automatic wait_soft;
    while (!soe) clks(1);
  endtask
  task automatic run_por(input logic [4:0] cfg, input logic slow, input int per);
    int n;
    por_cmd = 1'b1;
    strap_cfg = cfg;
    slow_lock = slow;
    clks(700);
    por_cmd = 1'b0;
    n = 0;
    // Count from release so the early part of the hard hold is not lost
    repeat (70) begin
      if (tick) n++;
      clks(1);
    end
    check("cfg", 16'({cfg_host, cfg_div, cfg_src}), 16'(cfg));
    check("held", 16'({hoe, soe, stoe, core_n}), 16'h2);
    check("open_drain", 16'({hout, sout}), 16'h0);
    check("pll_late", 16'(pto), 16'(slow));
    while (!hoe) begin
      if (tick) n++;
      clks(1);
    end
    check("hold", 16'(n >= 512), 16'h1);
    check("core_free", 16'(core_n), 16'h1);
    check("dll_late", 16'(dto), 16'(slow));
    n = 0;
    while (!soe) begin
      if (tick) n++;
      clks(1);
    end
    check("gap", 16'(n), 16'h10);
    check("straps_on", 16'(stoe), 16'h0);
    while (!tick) clks(1);
    clks(1);
    n = 1;
    while (!tick) begin
      n++;
      clks(1);
    end
    check("period", 16'(n), 16'(per));
    $display("power-on run done");
  endtask
  task automatic ext_hard_req;
    ext_hard = 1'b1;
    clks(500);
    check("hard_driven", 16'({hoe, core_n}), 16'h0);
    ext_hard = 1'b0;
    wait_soft();
    check("hard_back", 16'({hoe, core_n}), 16'h3);
    $display("hard request done");
  endtask
  task automatic ext_soft_req;
    ext_soft = 1'b1;
    clks(500);
    // Soft-only sequence keeps hard released but still holds core in reset
    check("soft_only", 16'({hoe, soe, core_n}), 16'h4);
    ext_soft = 1'b0;
    wait_soft();
    check("soft_back", 16'({hoe, core_n}), 16'h3);
    $display("soft request done");
  endtask
  task automatic ce_hold;
    ce = 1'b0;
    ext_soft = 1'b1;
    clks(500);
    check("ce_frozen", 16'({hoe, soe, core_n}), 16'h7);
    ext_soft = 1'b0;
    clks(2);
    ce = 1'b1;
    clks(500);
    check("ce_resume", 16'({hoe, soe, core_n}), 16'h7);
    $display("clock enable pause done");
  endtask
  initial begin
    clks(4);
    rst_n = 1'b1;
    run_por(5'h15, 1'b0, 8);
    run_por(5'h1A, 1'b1, 16);
    run_por(5'h0B, 1'b0, 12);
    ext_hard_req();
    ext_soft_req();
    ce_hold();
    stop_test();
  end
endmodule

// ---- rsq_reset_sva.sv ----
// Port checker of the reset sequencer
`timescale 1ns/1ps
module rsq_reset_sva (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic hard_reset_line_out, // Hard drive value
  input wire logic hard_reset_line_oe_n, // Hard drive enable
  input wire logic soft_reset_line_out, // Soft drive value
  input wire logic soft_reset_line_oe_n, // Soft drive enable
  input wire logic pll_lock_in, // PLL lock
  input wire logic strap_out_oe_n, // Strap drive enable
  input wire logic core_reset_n_q, // Core reset
  input wire logic sync_tick_q // Sync tick
);
  logic [9:0] hold_q;
  logic [4:0] gap_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) hold_q <= '0;
    else if (hard_reset_line_oe_n) hold_q <= '0;
    else if (sync_tick_q && hold_q != 10'h3FF) hold_q <= hold_q + 10'h1;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) gap_q <= '0;
    else if (!hard_reset_line_oe_n) gap_q <= '0;
    else if (sync_tick_q && gap_q != 5'h1F) gap_q <= gap_q + 5'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_hard_od; hard_reset_line_out == 1'b0; endproperty
  a_hard_od: assert property (p_hard_od) else $error("hard line driven high");
  property p_soft_od; soft_reset_line_out == 1'b0; endproperty
  a_soft_od: assert property (p_soft_od) else $error("soft line driven high");
  property p_strap_off; $fell(hard_reset_line_oe_n) |-> strap_out_oe_n; endproperty
  a_strap_off: assert property (p_strap_off) else $error("straps still driven");
  property p_strap_on; $rose(hard_reset_line_oe_n) |-> strap_out_oe_n; endproperty
  a_strap_on: assert property (p_strap_on) else $error("straps driven too soon");
  property p_core_pll; $rose(core_reset_n_q) |-> pll_lock_in; endproperty
  a_core_pll: assert property (p_core_pll) else $error("core out before lock");
  // Last tick may land on the release edge itself
  property p_hold; $rose(hard_reset_line_oe_n) |-> hold_q >= 10'h1FF; endproperty
  a_hold: assert property (p_hold) else $error("hard drive too short");
  property p_gap; $rose(soft_reset_line_oe_n) |-> gap_q >= 5'h0F; endproperty
  a_gap: assert property (p_gap) else $error("soft release too early");
  property p_core_hard; !hard_reset_line_oe_n |-> !core_reset_n_q; endproperty
  a_core_hard: assert property (p_core_hard) else $error("core free under hard");
  c_soft: cover property ($rose(soft_reset_line_oe_n));
  c_core: cover property ($rose(core_reset_n_q));
  c_hard: cover property ($fell(hard_reset_line_oe_n));
endmodule
bind rsq_reset_init_sequencer rsq_reset_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .hard_reset_line_out(hard_reset_line_out), .hard_reset_line_oe_n(hard_reset_line_oe_n),
  .soft_reset_line_out(soft_reset_line_out), .soft_reset_line_oe_n(soft_reset_line_oe_n),
  .pll_lock_in(pll_lock_in), .strap_out_oe_n(strap_out_oe_n),
  .core_reset_n_q(core_reset_n_q), .sync_tick_q(sync_tick_q));

// ---- rsq_sync_edge.sv ----
// Two-stage synchroniser with rising-edge detect for a group of pins
`timescale 1ns/1ps
module rsq_sync_edge #(
  parameter int W = 7
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] pin_in, // Asynchronous inputs
  output logic [W-1:0] level_q, // Synchronised levels
  output logic [W-1:0] rise // One-cycle rising edge pulses
);
  logic [W-1:0] meta_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      level_q <= '0;
      prev_q <= '0;
    end else if (ce) begin
      meta_q <= pin_in;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  assign rise = level_q & ~prev_q & {W{ce}};
endmodule
